// ### hw/perf_monitor_pkg.sv
package perf_monitor_pkg;

    localparam int unsigned DATA_W          = 32;
    localparam int unsigned SEL_W           = 5;
    localparam int unsigned EVENT_NUM_W     = 5;
    localparam int unsigned NUM_EVENTS      = 32;
    localparam int unsigned DEF_NUM_COUNTERS = 6;

    // Auxiliary control permission bit position
    localparam int unsigned AUX_PERM_BIT    = 12;

    // Configuration register field
    localparam int unsigned SECURE_EN_BIT   = 0;
    localparam logic        SECURE_EN_RESET = 1'h0;

    // Common event numbers
    localparam logic [7:0] EVT_CHAIN        = 8'h1E;
    localparam logic [7:0] EVT_BUS_CYCLES   = 8'h1D;
    localparam logic [7:0] EVT_MEMORY_ERROR = 8'h1A;
    localparam logic [7:0] EVT_BUS_ACCESS   = 8'h19;
    localparam logic [7:0] EVT_CPU_CYCLES   = 8'h11;

    // Common event identification bit positions
    localparam int unsigned CE_BIT_CHAIN      = 30;
    localparam int unsigned CE_BIT_BUS_CYCLES = 29;
    localparam int unsigned CE_BIT_MEM_ERROR  = 26;
    localparam int unsigned CE_BIT_BUS_ACCESS = 25;
    localparam int unsigned CE_BIT_CPU_CYCLES = 17;

    localparam logic [DATA_W-1:0] COMMON_EVENT_ID_LOW_VALUE =
        (32'h1 << CE_BIT_CHAIN) | (32'h1 << CE_BIT_BUS_CYCLES) |
        (32'h1 << CE_BIT_MEM_ERROR) | (32'h1 << CE_BIT_BUS_ACCESS) |
        (32'h1 << CE_BIT_CPU_CYCLES);

    // Register selectors on the system-register access port
    typedef enum logic [1:0] {
        REG_EVENT_TYPE_WINDOW    = 2'h0,
        REG_EVENT_COUNTER_WINDOW = 2'h1,
        REG_MONITOR_DEBUG_CONFIG = 2'h2,
        REG_COMMON_EVENT_ID_LOW  = 2'h3
    } reg_id_e;

    typedef enum logic [1:0] {
        PRIV_LEVEL_0 = 2'h0,
        PRIV_LEVEL_1 = 2'h1,
        PRIV_LEVEL_2 = 2'h2,
        PRIV_LEVEL_3 = 2'h3
    } priv_level_e;

    typedef struct packed {
        logic              valid;
        logic              write;
        reg_id_e           reg_id;
        priv_level_e       level;
        logic [DATA_W-1:0] wdata;
    } sysreg_req_s;

    typedef struct packed {
        logic              valid;
        logic              trap;
        priv_level_e       trap_level;
        logic [DATA_W-1:0] rdata;
    } sysreg_rsp_s;

endpackage

// ### hw/event_counter_slice.sv
module event_counter_slice #(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic             clock,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             increment,
    output logic      [WIDTH-1:0] count,
    output logic                  overflow
);

    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;

    // Software load takes priority over a counted event
    always_comb begin
        nxt_count = count_ff;
        if (load) begin
            nxt_count = load_value;
        end else if (increment) begin
            nxt_count = count_ff + WIDTH'(1);
        end
    end

    // Warm-domain storage, no defined reset value
    always_ff @(posedge clock) begin
        count_ff <= nxt_count;
    end

    assign count    = count_ff;
    assign overflow = increment && !load && (count_ff == '1);

endmodule

// ### hw/cluster_perf_monitor_regs.sv
// Notes on behaviour
// - Privilege-1 window writes need level-3 aux bit 12 and (level-2 bit 12 or secure).
// - A refused write traps to the lowest level, 2 or 3, that denied it.
// - The 32-bit counter window reads and writes the counter named by the select field.
// - Selection is taken afresh from the select field on every window access.
// - Counter window storage is warm-domain and has no defined reset value.
// - Configuration bit 0 enables counting of secure events when set.
// - The secure-event enable clears to zero on reset.
// - Configuration register is reached only from privilege level 3; others are refused.
// - Common-event identification register is read-only; writes do nothing.
// - Each identification bit reads 1 when its common event can be counted.
// - Chain, bus cycles, memory error, bus access and processor cycles are implemented.
// - Chained odd counter counts overflows of the even counter below; even never counts.
// - The event-type window follows the select field like the counter window.
module cluster_perf_monitor_regs #(
    parameter int unsigned NUM_COUNTERS = perf_monitor_pkg::DEF_NUM_COUNTERS
) (
    input  wire logic                                 clock,
    input  wire logic                                 rst_n,
    input  wire perf_monitor_pkg::sysreg_req_s        req,
    output perf_monitor_pkg::sysreg_rsp_s             rsp,
    input  wire logic [perf_monitor_pkg::SEL_W-1:0]   counter_select_field,
    input  wire logic [perf_monitor_pkg::DATA_W-1:0]  level3_aux_control,
    input  wire logic [perf_monitor_pkg::DATA_W-1:0]  level2_aux_control,
    input  wire logic                                 non_secure_state_flag,
    input  wire logic [perf_monitor_pkg::NUM_EVENTS-1:0] event_in,
    input  wire logic                                 event_secure,
    output logic                                      secure_event_count_enable,
    output logic [NUM_COUNTERS-1:0]                   counter_overflow
);

    localparam int unsigned DW = perf_monitor_pkg::DATA_W;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [DW-1:0]           indexed_event_type [NUM_COUNTERS];
    logic [DW-1:0]           nxt_event_type     [NUM_COUNTERS];
    logic [DW-1:0]           indexed_event_counter [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] counter_load;
    logic [NUM_COUNTERS-1:0] counter_increment;
    logic [NUM_COUNTERS-1:0] counter_ovf;

    logic                    secure_en_ff;
    logic                    nxt_secure_en;
    perf_monitor_pkg::sysreg_rsp_s rsp_ff;
    perf_monitor_pkg::sysreg_rsp_s nxt_rsp;

    logic                    sel_valid;
    logic                    window_write_ok;
    logic                    window_access;
    logic                    write_granted;
    logic                    type_write;
    logic                    cnt_write;
    logic                    secure_blocked;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Decodes whether a counter index is implemented
    function automatic logic index_valid(input logic [perf_monitor_pkg::SEL_W-1:0] idx);
        index_valid = (32'(idx) < NUM_COUNTERS);
    endfunction

    // Decodes whether a counter index equals the current select field
    function automatic logic is_selected(input int unsigned idx,
                                         input logic [perf_monitor_pkg::SEL_W-1:0] sel);
        is_selected = (32'(sel) == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Permission gating

    assign sel_valid     = index_valid(counter_select_field);
    assign window_access = req.valid &&
                           ((req.reg_id == perf_monitor_pkg::REG_EVENT_COUNTER_WINDOW) ||
                            (req.reg_id == perf_monitor_pkg::REG_EVENT_TYPE_WINDOW));

    // Level-1 writes need level-3 permission plus level-2 permission or secure state
    assign window_write_ok =
        (req.level != perf_monitor_pkg::PRIV_LEVEL_1) ||
        (level3_aux_control[perf_monitor_pkg::AUX_PERM_BIT] &&
         (level2_aux_control[perf_monitor_pkg::AUX_PERM_BIT] ||
          !non_secure_state_flag));

    assign write_granted = window_access && req.write && window_write_ok;
    assign cnt_write     = write_granted && sel_valid &&
                           (req.reg_id == perf_monitor_pkg::REG_EVENT_COUNTER_WINDOW);
    assign type_write    = write_granted && sel_valid &&
                           (req.reg_id == perf_monitor_pkg::REG_EVENT_TYPE_WINDOW);

    ////////////////////////////////////////////////////////////////////////////
    // Secure-event enable

    always_comb begin
        nxt_secure_en = secure_en_ff;
        if (req.valid && req.write &&
            (req.reg_id == perf_monitor_pkg::REG_MONITOR_DEBUG_CONFIG) &&
            (req.level == perf_monitor_pkg::PRIV_LEVEL_3)) begin
            nxt_secure_en = req.wdata[perf_monitor_pkg::SECURE_EN_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            secure_en_ff <= perf_monitor_pkg::SECURE_EN_RESET;
        end else begin
            secure_en_ff <= nxt_secure_en;
        end
    end

    assign secure_event_count_enable = secure_en_ff;
    assign secure_blocked            = event_secure && !secure_en_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Event counters and event types

    generate
        for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_counter
            logic is_chain;
            logic plain_hit;

            assign is_chain  = (indexed_event_type[i] == DW'(perf_monitor_pkg::EVT_CHAIN));
            assign plain_hit = (indexed_event_type[i][DW-1:perf_monitor_pkg::EVENT_NUM_W]
                                == '0) &&
                               event_in[indexed_event_type[i]
                                        [perf_monitor_pkg::EVENT_NUM_W-1:0]];

            if ((i % 2) == 1) begin : g_odd
                assign counter_increment[i] = is_chain ? counter_ovf[i-1]
                                                       : (plain_hit && !secure_blocked);
            end else begin : g_even
                assign counter_increment[i] = !is_chain && plain_hit && !secure_blocked;
            end

            assign counter_load[i] = cnt_write && is_selected(i, counter_select_field);

            event_counter_slice #(
                .WIDTH (DW)
            ) u_counter (
                .clock      (clock),
                .load       (counter_load[i]),
                .load_value (req.wdata),
                .increment  (counter_increment[i]),
                .count      (indexed_event_counter[i]),
                .overflow   (counter_ovf[i])
            );

            always_comb begin
                nxt_event_type[i] = indexed_event_type[i];
                if (type_write && is_selected(i, counter_select_field)) begin
                    nxt_event_type[i] = req.wdata;
                end
            end

            // Warm-domain storage, no defined reset value
            always_ff @(posedge clock) begin
                indexed_event_type[i] <= nxt_event_type[i];
            end
        end
    endgenerate

    assign counter_overflow = counter_ovf;

    ////////////////////////////////////////////////////////////////////////////
    // Access response

    always_comb begin
        nxt_rsp            = '0;
        nxt_rsp.valid      = req.valid;
        nxt_rsp.trap_level = perf_monitor_pkg::PRIV_LEVEL_0;
        if (req.valid) begin
            unique case (req.reg_id)
                perf_monitor_pkg::REG_EVENT_COUNTER_WINDOW,
                perf_monitor_pkg::REG_EVENT_TYPE_WINDOW: begin
                    if (req.write && !window_write_ok) begin
                        nxt_rsp.trap = 1'h1;
                        // Level 2 is lower, so it wins whenever it also denied
                        nxt_rsp.trap_level =
                            (non_secure_state_flag &&
                             !level2_aux_control[perf_monitor_pkg::AUX_PERM_BIT])
                            ? perf_monitor_pkg::PRIV_LEVEL_2
                            : perf_monitor_pkg::PRIV_LEVEL_3;
                    end else if (!req.write && sel_valid) begin
                        for (int unsigned k = 0; k < NUM_COUNTERS; k++) begin
                            if (is_selected(k, counter_select_field)) begin
                                nxt_rsp.rdata =
                                    (req.reg_id == perf_monitor_pkg::REG_EVENT_COUNTER_WINDOW)
                                    ? indexed_event_counter[k]
                                    : indexed_event_type[k];
                            end
                        end
                    end
                end
                perf_monitor_pkg::REG_MONITOR_DEBUG_CONFIG: begin
                    if (req.level != perf_monitor_pkg::PRIV_LEVEL_3) begin
                        nxt_rsp.trap       = 1'h1;
                        nxt_rsp.trap_level = perf_monitor_pkg::PRIV_LEVEL_3;
                    end else if (!req.write) begin
                        nxt_rsp.rdata[perf_monitor_pkg::SECURE_EN_BIT] = secure_en_ff;
                    end
                end
                perf_monitor_pkg::REG_COMMON_EVENT_ID_LOW: begin
                    if (!req.write) begin
                        nxt_rsp.rdata = perf_monitor_pkg::COMMON_EVENT_ID_LOW_VALUE;
                    end
                    // Writes complete with no effect
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp;
        end
    end

    assign rsp = rsp_ff;

endmodule

// ### testbench/cluster_perf_monitor_regs_properties.sv
module cluster_perf_monitor_regs_properties #(
    parameter int unsigned NUM_COUNTERS = perf_monitor_pkg::DEF_NUM_COUNTERS
) (
    input wire logic                                    clock,
    input wire logic                                    rst_n,
    input wire perf_monitor_pkg::sysreg_req_s           req,
    input wire perf_monitor_pkg::sysreg_rsp_s           rsp,
    input wire logic [perf_monitor_pkg::SEL_W-1:0]      counter_select_field,
    input wire logic [perf_monitor_pkg::DATA_W-1:0]     level3_aux_control,
    input wire logic [perf_monitor_pkg::DATA_W-1:0]     level2_aux_control,
    input wire logic                                    non_secure_state_flag,
    input wire logic [perf_monitor_pkg::NUM_EVENTS-1:0] event_in,
    input wire logic                                    event_secure,
    input wire logic                                    secure_event_count_enable,
    input wire logic [NUM_COUNTERS-1:0]                 counter_overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    logic       win_w;
    logic       perm;
    logic       cfg;
    logic       cfg3_w;
    logic       ceid;
    logic [1:0] deny_lvl;
    assign win_w = req.valid && req.write && req.level == perf_monitor_pkg::PRIV_LEVEL_1
                   && req.reg_id inside {2'h0, 2'h1};
    assign perm = level3_aux_control[12] && (level2_aux_control[12] || !non_secure_state_flag);
    assign cfg = req.valid && req.reg_id == perf_monitor_pkg::REG_MONITOR_DEBUG_CONFIG;
    assign cfg3_w = cfg && req.write && req.level == perf_monitor_pkg::PRIV_LEVEL_3;
    assign ceid = req.valid && req.reg_id == perf_monitor_pkg::REG_COMMON_EVENT_ID_LOW;
    assign deny_lvl = (non_secure_state_flag && !level2_aux_control[12]) ? 2'h2 : 2'h3;
    ////////////////////////////////////////////////////////////////////////////
    sequence s_denied; win_w && !perm; endsequence
    property p_answer; req.valid |=> rsp.valid; endproperty
    property p_deny; s_denied |=> rsp.trap; endproperty
    property p_deny_level; s_denied |=> rsp.trap_level == $past(deny_lvl); endproperty
    property p_allow; win_w && perm |=> !rsp.trap; endproperty
    property p_cfg_refuse;
        cfg && req.level != perf_monitor_pkg::PRIV_LEVEL_3 |=> rsp.trap && rsp.trap_level == 2'h3;
    endproperty
    property p_cfg_write; cfg3_w |=> secure_event_count_enable == $past(req.wdata[0]); endproperty
    property p_cfg_hold; !cfg3_w |=> $stable(secure_event_count_enable); endproperty
    property p_cfg_read;
        cfg && !req.write && req.level == perf_monitor_pkg::PRIV_LEVEL_3
        |=> rsp.rdata == {31'h0, $past(secure_event_count_enable)};
    endproperty
    property p_ceid_read;
        ceid && !req.write |=> rsp.rdata == perf_monitor_pkg::COMMON_EVENT_ID_LOW_VALUE;
    endproperty
    property p_ceid_write; ceid && req.write |=> !rsp.trap; endproperty
    a_answer: assert property (p_answer) else $error("no response after request");
    a_deny: assert property (p_deny) else $error("window write not refused");
    a_deny_level: assert property (p_deny_level) else $error("wrong trap level");
    a_allow: assert property (p_allow) else $error("permitted write trapped");
    a_cfg_refuse: assert property (p_cfg_refuse) else $error("low level config access");
    a_cfg_write: assert property (p_cfg_write) else $error("enable not written");
    a_cfg_hold: assert property (p_cfg_hold) else $error("enable changed");
    a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");
    a_ceid_read: assert property (p_ceid_read) else $error("id value wrong");
    a_ceid_write: assert property (p_ceid_write) else $error("id write trapped");
endmodule

bind cluster_perf_monitor_regs cluster_perf_monitor_regs_properties #(
    .NUM_COUNTERS(NUM_COUNTERS)
) u_props (.clock(clock), .rst_n(rst_n), .req(req), .rsp(rsp),
    .counter_select_field(counter_select_field), .level3_aux_control(level3_aux_control),
    .level2_aux_control(level2_aux_control), .non_secure_state_flag(non_secure_state_flag),
    .event_in(event_in), .event_secure(event_secure),
    .secure_event_count_enable(secure_event_count_enable), .counter_overflow(counter_overflow));

// ### testbench/cluster_perf_monitor_regs_bench.sv
module cluster_perf_monitor_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         clock;
    logic                         rst_n;
    perf_monitor_pkg::sysreg_req_s req;
    perf_monitor_pkg::sysreg_rsp_s rsp;
    logic [4:0]                   sel;
    logic [31:0]                  l3;
    logic [31:0]                  l2;
    logic                         ns;
    logic [31:0]                  event_in;
    logic                         event_secure;
    logic                         sec_en;
    logic [5:0]                   ovf;
    logic                         ovf_seen;
    logic                         ok;
    logic [31:0]                  rd;
    logic [31:0]                  prior;
    logic [2:0]                   tr;
    int                           err_total;
    int                           checked;

    cluster_perf_monitor_regs #(.NUM_COUNTERS(6)) dut (.clock(clock), .rst_n(rst_n),
        .req(req), .rsp(rsp), .counter_select_field(sel), .level3_aux_control(l3),
        .level2_aux_control(l2), .non_secure_state_flag(ns), .event_in(event_in),
        .event_secure(event_secure), .secure_event_count_enable(sec_en),
        .counter_overflow(ovf));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (ovf[0] === 1'b1) ovf_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task acc(input logic w, input logic [1:0] id, input logic [1:0] lv, input logic [31:0] d,
             input logic [4:0] s);
        @(posedge clock);
        req <= '{1'b1, w, perf_monitor_pkg::reg_id_e'(id), perf_monitor_pkg::priv_level_e'(lv), d};
        sel <= s;
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        rd = rsp.rdata;
        tr = {rsp.trap, rsp.trap_level};
        chk("response valid", 1, rsp.valid);
    endtask

    task pulse(input int e, input int n);
        @(posedge clock);
        event_in <= 32'h1 << e;
        repeat (n) @(posedge clock);
        event_in <= '0;
    endtask

    task test_done;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #5000;
        err_total++;
        test_done;
    end

    initial begin
        {rst_n, ns, event_secure, ovf_seen, sel, l3, l2, event_in} = '0;
        req = '0;
        err_total = 0;
        checked = 0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1 chk("enable", 0, sec_en);
        acc(0, 2, 3, 0, 0); chk("config", 0, rd);
        acc(1, 2, 3, 32'hFFFFFFFF, 0);
        acc(0, 2, 3, 0, 0); chk("config", 1, rd);
        chk("enable", 1, sec_en);
        acc(1, 2, 1, 0, 0); chk("trap", 3'h7, tr);
        acc(0, 2, 3, 0, 0); chk("config", 1, rd);
        acc(1, 2, 3, 0, 0);
        acc(1, 3, 3, 0, 0); chk("trap", 0, tr);
        acc(0, 3, 1, 0, 0); chk("id", 32'h66020000, rd);
        for (int i = 0; i < 3; i++) acc(1, 1, 3, 32'hA0 + i, i[4:0]);
        for (int i = 0; i < 3; i++) begin
            acc(0, 1, 3, 0, i[4:0]); chk("counter", 32'hA0 + i, rd);
        end
        acc(1, 0, 3, perf_monitor_pkg::EVT_CPU_CYCLES, 0);
        acc(1, 0, 3, perf_monitor_pkg::EVT_CHAIN, 1);
        acc(1, 0, 3, perf_monitor_pkg::EVT_CHAIN, 2);
        acc(0, 0, 3, 0, 1); chk("type", 32'h1E, rd);
        acc(1, 1, 3, 32'hFFFFFFFE, 0);
        acc(1, 1, 3, 0, 1);
        acc(1, 1, 3, 5, 2);
        pulse(17, 2);
        acc(0, 1, 3, 0, 0); chk("counter0", 0, rd);
        acc(0, 1, 3, 0, 1); chk("counter1", 1, rd);
        acc(0, 1, 3, 0, 2); chk("counter2", 5, rd);
        chk("overflow", 1, ovf_seen);
        @(posedge clock);
        event_secure <= 1'b1;
        pulse(17, 3);
        acc(0, 1, 3, 0, 0); chk("secure blocked", 0, rd);
        acc(1, 2, 3, 1, 0);
        pulse(17, 3);
        acc(0, 1, 3, 0, 0); chk("secure counted", 3, rd);
        prior = 5;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            l3 <= {19'h0, i[2], 12'h0};
            l2 <= {19'h0, i[1], 12'h0};
            ns <= i[0];
            ok = i[2] && (i[1] || !i[0]);
            acc(1, 1, 1, 32'h100 + i, 2);
            chk("trap", ok ? 3'h0 : ((i[0] && !i[1]) ? 3'h6 : 3'h7), tr);
            if (ok) prior = 32'h100 + i;
            acc(0, 1, 3, 0, 2); chk("counter2", prior, rd);
        end
        test_done;
    end
endmodule
